/* hw/uisc_map.svh */
`ifndef UISC_MAP_SVH
`define UISC_MAP_SVH

// register offsets on the internal register port
`define UISC_ISC_OFFSET 4'h0f
`define UISC_SFR_OFFSET 4'h07
`define UISC_LCR_OFFSET 4'h03
// access key for the special register bank
`define UISC_LCR_KEY 8'hbf
`define UISC_SFR_EN_BIT 2
// field positions of the status register
`define UISC_BIT_FLOW 7
`define UISC_BIT_XOFF 6
`define UISC_BIT_MODEM 5
`define UISC_BIT_THR 4
`define UISC_BIT_RXTO 3
`define UISC_BIT_RHR 2
`define UISC_BIT_LERR 1
`define UISC_BIT_CLR 0
`define UISC_ISC_RESET 8'h00
`define UISC_NUM_SRC 7

`endif

/* hw/uisc_pkg.sv */
package uisc_pkg;
    // one bus access on the internal register port
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [3:0] addr;
        logic [7:0] wdata;
    } uisc_req_t;
    // interrupt source events, bit n-1 feeds status bit n
    typedef logic [6:0] uisc_src_t;
endpackage

/* hw/uisc_top.sv */
`timescale 1ns/1ns
`include "uisc_map.svh"

module uisc_top (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire uisc_pkg::uisc_req_t req_i,
    input wire logic [7:0] line_control_register_i,
    input wire logic [7:0] special_function_register_i,
    input wire uisc_pkg::uisc_src_t src_evt_i,
    output logic [7:0] rdata_o,
    output logic rvalid_o,
    output logic [6:0] pending_o
);

    // ========================================
    // constants
    // ========================================
    // reset image of the whole register, clear bit included
    localparam logic [7:0] ISC_RESET = `UISC_ISC_RESET;

    // ========================================
    // access decode
    // ========================================
    logic bank_open;
    logic hit;
    logic rd_hit;
    logic clr_wr;

    // gated decode
    // both keys must hold in the same cycle; either one alone keeps the
    // offset dark, so a stray access can never clear the flags
    assign bank_open = (line_control_register_i == `UISC_LCR_KEY) &&
                       special_function_register_i[`UISC_SFR_EN_BIT];
    assign hit = bank_open && (req_i.addr == `UISC_ISC_OFFSET);
    assign rd_hit = hit && req_i.rd;

    // clear-all strobe
    // the bit is never stored, so it is back at 0 the cycle after the write
    assign clr_wr = hit && req_i.wr && req_i.wdata[`UISC_BIT_CLR];

    // ========================================
    // status flags
    // ========================================
    logic [6:0] flags_q;

    // one sticky flag per source
    // a new event beats a clear in the same cycle, so an event that lands
    // in the same cycle as the host's clear is still reported later
    for (genvar gi = 0; gi < `UISC_NUM_SRC; gi++) begin : g_flag
        logic flag_q;
        always_ff @(posedge core_clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                flag_q <= ISC_RESET[gi + 1];
            end else if (src_evt_i[gi]) begin
                flag_q <= 1'b1;
            end else if (clr_wr) begin
                flag_q <= 1'b0;
            end
        end
        // one driver per bit of the flag vector
        assign flags_q[gi] = flag_q;
    end

    // ========================================
    // read path
    // ========================================
    logic [7:0] rdata_q;
    logic rvalid_q;

    // bit 0 always reads 0; data is zero outside a read, so a
    // stale byte is never mistaken for an answer
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_q <= ISC_RESET;
        end else if (rd_hit) begin
            rdata_q <= {flags_q, 1'b0};
        end else begin
            rdata_q <= 8'h00;
        end
    end

    // read strobe, one cycle per accepted read
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= rd_hit;
        end
    end

    // outputs come straight from the flops
    assign rdata_o = rdata_q;
    assign rvalid_o = rvalid_q;
    assign pending_o = flags_q;

    // ========================================
    // checks
    // ========================================
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);

    clear_all_flags_a: assert property (
        clr_wr |=> flags_q == $past(src_evt_i))
        else $error("clear-all did not clear flags");

    event_sets_flag_a: assert property (
        src_evt_i[`UISC_BIT_LERR - 1] |=> flags_q[`UISC_BIT_LERR - 1])
        else $error("line error flag not set");

    flag_holds_a: assert property (
        flags_q[6] && !clr_wr |=> flags_q[6])
        else $error("flow flag lost");

    rhr_bit_a: assert property (
        src_evt_i[`UISC_BIT_RHR - 1] |=> pending_o[`UISC_BIT_RHR - 1])
        else $error("rhr flag not set");

    locked_read_a: assert property (
        req_i.rd && !bank_open |=> !rvalid_o)
        else $error("read answered while locked");

    read_layout_a: assert property (
        rd_hit |=> rvalid_o && rdata_o == {$past(flags_q), 1'b0})
        else $error("read data layout wrong");

    clr_bit_zero_a: assert property (
        rvalid_o |-> !rdata_o[`UISC_BIT_CLR])
        else $error("clear bit read as one");

    thr_sticky_a: assert property (
        src_evt_i[3] ##1 !clr_wr[*2] |=> flags_q[3])
        else $error("thr flag dropped");

    enable_bit_a: assert property (
        !special_function_register_i[2] |-> !hit)
        else $error("decode without enable");

    flow_bit_a: assert property (
        src_evt_i[`UISC_BIT_FLOW - 1] |=> pending_o[`UISC_BIT_FLOW - 1])
        else $error("flow flag not set");

    xoff_bit_a: assert property (
        src_evt_i[`UISC_BIT_XOFF - 1] |=> pending_o[`UISC_BIT_XOFF - 1])
        else $error("flow-off flag not set");

    modem_bit_a: assert property (
        src_evt_i[`UISC_BIT_MODEM - 1] |=> pending_o[`UISC_BIT_MODEM - 1])
        else $error("modem flag not set");

    rxto_bit_a: assert property (
        src_evt_i[`UISC_BIT_RXTO - 1] |=> pending_o[`UISC_BIT_RXTO - 1])
        else $error("timeout flag not set");

    reset_zero_a: assert property (
        @(posedge core_clk_i) disable iff (1'b0)
        !rst_n_i |-> pending_o == 7'h00 && rdata_o == 8'h00 && !rvalid_o)
        else $error("outputs not zero in reset");

    idle_data_a: assert property (
        !rvalid_o |-> rdata_o == 8'h00)
        else $error("read data outside a read");

    flag_source_a: assert property (
        (flags_q & ~$past(flags_q) & ~$past(src_evt_i)) == 7'h00)
        else $error("flag set without event");

    locked_write_a: assert property (
        !bank_open |=> (~flags_q & $past(flags_q)) == 7'h00)
        else $error("flag cleared while locked");

    write_no_answer_a: assert property (
        req_i.wr && !req_i.rd |=> !rvalid_o)
        else $error("write answered as a read");

    // main scenarios
    read_cov_c: cover property (rd_hit && flags_q != 7'h00);
    clear_cov_c: cover property (clr_wr && flags_q != 7'h00);
    race_cov_c: cover property (clr_wr && src_evt_i != 7'h00);
    locked_cov_c: cover property (req_i.wr && !bank_open);

endmodule

/* test/uisc_host_model.sv */
`timescale 1ns/1ns
`include "uisc_map.svh"
// =====
// host side: opens or shuts the special bank, issues accesses
module uisc_host_model (
    input wire logic core_clk_i,
    input wire logic rd_i,
    input wire logic wr_i,
    input wire logic open_i,
    input wire logic [7:0] wdata_i,
    output uisc_pkg::uisc_req_t req_o,
    output logic [7:0] lcr_o,
    output logic [7:0] sfr_o
);
    // bank key: both values needed, shut clears the enable bit and sets every other bit
    always_ff @(posedge core_clk_i) begin
        lcr_o <= `UISC_LCR_KEY;
        sfr_o <= open_i ? 8'h04 : 8'hfb;
        req_o.rd <= rd_i;
        req_o.wr <= wr_i;
        req_o.addr <= `UISC_ISC_OFFSET;
        // idle data flips so stale bytes never look valid
        req_o.wdata <= (rd_i | wr_i) ? wdata_i : ~req_o.wdata;
    end
endmodule

/* test/uisc_top_tb_top.sv */
`timescale 1ns/1ns
module uisc_top_tb_top;
    logic core_clk_i = 0, rst_n_i = 0, rd = 0, wr = 0, opn = 0, rvalid_o;
    logic [7:0] rdata_o, line_control_register, special_function_register, exp_q[$];
    logic [6:0] src = 0, acc = 0, pending_o;
    logic [31:0] lf = 32'h0825_ed64;
    logic [7:0] wd = 8'h01;
    uisc_pkg::uisc_req_t req;
    int error_cnt = 0, samples_checked = 0, cyc = 0;
    uisc_host_model host (.core_clk_i(core_clk_i), .rd_i(rd), .wr_i(wr),
        .open_i(opn), .wdata_i(wd), .req_o(req), .lcr_o(line_control_register), .sfr_o(special_function_register));
    uisc_top dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .req_i(req),
        .line_control_register_i(line_control_register), .special_function_register_i(special_function_register),
        .src_evt_i(src), .rdata_o(rdata_o), .rvalid_o(rvalid_o),
        .pending_o(pending_o));
    initial forever #5 core_clk_i = ~core_clk_i;
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task cmp(input logic [7:0] e, input logic [7:0] a);
        samples_checked++;
        if (a !== e) begin
            error_cnt++;
            $display("Error t=%0t exp %h got %h", $time, e, a);
        end
    endtask
    task end_sim;
        $display("checked %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // one access; reads in the open bank leave a note; then let it settle
    task op(input logic o, input logic w, input logic [7:0] e);
        @(posedge core_clk_i);
        rd <= !w;
        wr <= w;
        opn <= o;
        @(posedge core_clk_i);
        rd <= 0;
        wr <= 0;
        if (o && !w) exp_q.push_back(e);
        repeat (3) @(posedge core_clk_i);
        cmp({1'b0, acc}, {1'b0, pending_o});
    endtask
    // =====
    // monitor: stray read data meets 8'hff, which bit 0 can never show
    always @(posedge core_clk_i) begin
        cyc++;
        if (cyc > 3000) begin
            error_cnt++;
            end_sim;
        end else if (rvalid_o === 1'b1)
            cmp(exp_q.size() ? exp_q.pop_front() : 8'hff, rdata_o);
    end
    initial begin
        repeat (12) @(posedge core_clk_i);
        rst_n_i <= 1;
        op(1, 0, 8'h00);
        for (int i = 0; i < 34; i++) begin
            lf = lfsr(lf);
            @(posedge core_clk_i);
            src <= (i < 7) ? 7'h01 << i : lf[6:0];
            @(posedge core_clk_i);
            src <= 0;
            acc = acc | ((i < 7) ? 7'h01 << i : lf[6:0]);
            op(1, 0, {acc, 1'b0});
            op(0, 0, 8'h00);
            // bit 0 of the written byte and the open bank (lf[8]) decide whether the write clears
            wd <= {lf[15:9], lf[9]};
            if (lf[8] && lf[9]) acc = 0;
            op(lf[8], 1, 8'h00);
        end
        cmp(8'h00, 8'(exp_q.size()));
        end_sim;
    end
endmodule
